/* File: hw/acb_pkg.sv */
// Purpose: Shared constants and types for the analog control register bank
// Assumes: 200 MHz core clock, byte-wide registers on the serial control port
// Notes:   Converter clock periods are derived from their frequencies, soft-start cycles from its base time
package acb_pkg;

   // Clock
   localparam int unsigned CLK_KHZ = 200000;

   // Register offsets
   localparam logic [7:0] OFS_BIAS_CONTROL = 8'h0c;
   localparam logic [7:0] OFS_GAMMA_SENSOR_CONTROL = 8'h0d;
   localparam logic [7:0] OFS_CATHODE_MODE = 8'h0e;
   localparam logic [7:0] OFS_CATHODE_CONVERTER_CONTROL = 8'h0f;
   localparam logic [7:0] OFS_PIXEL_VOLTAGE_CEILING = 8'h10;
   localparam logic [7:0] OFS_CATHODE_LEVEL = 8'h11;
   localparam logic [7:0] OFS_PEAK_CURRENT_REFERENCE = 8'h12;
   localparam logic [7:0] OFS_DIMMING_LEVEL = 8'h13;
   localparam logic [7:0] OFS_SENSOR_GAIN = 8'h14;
   localparam logic [7:0] OFS_SENSOR_OFFSET = 8'h15;
   localparam logic [7:0] OFS_SENSOR_UPDATE_INTERVAL = 8'h16;
   localparam logic [7:0] OFS_TEMPERATURE_READING = 8'h17;

   // Reset values
   localparam logic [7:0] RST_BIAS_CONTROL = 8'h03;
   localparam logic [7:0] RST_GAMMA_SENSOR_CONTROL = 8'h07;
   localparam logic [7:0] RST_CATHODE_MODE = 8'h00;
   localparam logic [7:0] RST_CATHODE_CONVERTER_CONTROL = 8'h3d;
   localparam logic [7:0] RST_PIXEL_VOLTAGE_CEILING = 8'h0d;
   localparam logic [7:0] RST_CATHODE_LEVEL = 8'h51;
   localparam logic [7:0] RST_PEAK_CURRENT_REFERENCE = 8'h00;
   localparam logic [7:0] RST_DIMMING_LEVEL = 8'h64;
   localparam logic [7:0] RST_SENSOR_GAIN = 8'h19;
   localparam logic [7:0] RST_SENSOR_OFFSET = 8'h5d;
   localparam logic [7:0] RST_SENSOR_UPDATE_INTERVAL = 8'hfe;
   localparam logic [7:0] RST_TEMPERATURE_READING = 8'h00;

   // Field positions
   localparam int unsigned POS_EXT_REF = 7;
   localparam int unsigned POS_BIAS_LSB = 0;
   localparam int unsigned POS_PUMP_HOLD = 7;
   localparam int unsigned POS_GSENSE_HOLD = 6;
   localparam int unsigned POS_GSTEP_LSB = 0;
   localparam int unsigned POS_ISENSE_LSB = 2;
   localparam int unsigned POS_MODE_LSB = 0;
   localparam int unsigned POS_SS_BYPASS = 7;
   localparam int unsigned POS_DUTY_LSB = 4;
   localparam int unsigned POS_FREQ_LSB = 2;
   localparam int unsigned POS_SS_LSB = 0;
   localparam int unsigned POS_COARSE_LSB = 5;
   localparam int unsigned POS_FINE_LSB = 0;

   // Field codes
   localparam logic [1:0] MODE_FIXED_CURRENT = 2'h0;
   localparam logic [1:0] MODE_CLAMPED_CURRENT = 2'h1;
   localparam logic [1:0] MODE_MANUAL_VOLTAGE = 2'h2;
   localparam logic [2:0] DUTY_HALF = 3'h3;
   localparam logic [2:0] DUTY_FORBIDDEN = 3'h7;
   localparam logic [2:0] GSTEP_FULL = 3'h7;
   localparam logic [2:0] COARSE_MAX = 3'h4;
   localparam logic [6:0] DIM_UNITY = 7'h64;
   localparam logic [7:0] INTERVAL_MIN = 8'h02;

   // Converter clock frequencies in kHz
   localparam int unsigned FREQ0_KHZ = 125;
   localparam int unsigned FREQ1_KHZ = 250;
   localparam int unsigned FREQ2_KHZ = 500;
   localparam int unsigned FREQ3_KHZ = 900;
   localparam logic [10:0] PER0_CYC = 11'(CLK_KHZ / FREQ0_KHZ);
   localparam logic [10:0] PER1_CYC = 11'(CLK_KHZ / FREQ1_KHZ);
   localparam logic [10:0] PER2_CYC = 11'(CLK_KHZ / FREQ2_KHZ);
   localparam logic [10:0] PER3_CYC = 11'(CLK_KHZ / FREQ3_KHZ);

   // Soft-start base time; codes double it
   localparam int unsigned SS_BASE_MS = 2;
   localparam int unsigned SS_BASE_CYC = SS_BASE_MS * CLK_KHZ;

   // Grouped decoded converter settings
   typedef struct packed {
      logic [1:0] freq;
      logic [2:0] duty;
      logic [1:0] ss_code;
      logic ss_bypass;
   } acb_conv_cfg_t;

   typedef enum logic [2:0] {
      SS_IDLE = 3'b001,
      SS_RAMP = 3'b010,
      SS_DONE = 3'b100
   } acb_ss_state_t;

   function automatic logic [10:0] conv_period(input logic [1:0] freq);
      case (freq)
         2'h0: conv_period = PER0_CYC;
         2'h1: conv_period = PER1_CYC;
         2'h2: conv_period = PER2_CYC;
         default: conv_period = PER3_CYC;
      endcase
   endfunction

   function automatic logic [10:0] conv_high(input logic [10:0] per, input logic [2:0] duty);
      logic [13:0] prod;
      logic [2:0] d;
      d = (duty == DUTY_FORBIDDEN) ? DUTY_HALF : duty;
      prod = 14'(per) * 14'({1'b0, d} + 4'h1);
      conv_high = prod[13:3];
   endfunction

endpackage

/* File: hw/acb_conv_clock.sv */
// Purpose: Converter clock generator with selectable frequency and duty
// Assumes: Settings may change at any time; new values apply at next period
// Notes:   Output is registered
`timescale 1ns/1ps
`default_nettype none
module acb_conv_clock (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Settings
   input wire logic [1:0] freq_in,
   input wire logic [2:0] duty_in,
   // Clock out
   output logic conv_clk_out
);
   import acb_pkg::*;

   logic [10:0] cnt_q;
   logic [10:0] per_q;
   logic [10:0] high_q;

   // Period and high time latched at each wrap
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         cnt_q <= 11'h000;
         per_q <= PER3_CYC;
         high_q <= 11'(PER3_CYC >> 1);
      end else if (cnt_q >= per_q - 11'h001) begin
         cnt_q <= 11'h000;
         per_q <= conv_period(freq_in); // see [RQ11]
         high_q <= conv_high(conv_period(freq_in), duty_in); // see [RQ10]
      end else begin
         cnt_q <= cnt_q + 11'h001;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         conv_clk_out <= 1'b0;
      end else begin
         conv_clk_out <= (cnt_q < high_q); // see [RQ10]
      end
   end
endmodule
`default_nettype wire

/* File: hw/acb_temp_sensor.sv */
// Purpose: Frame-paced temperature conversion control and saturating readout
// Assumes: Converter result arrives as a signed code with a valid strobe
// Notes:   Counter reloads after every update
`timescale 1ns/1ps
`default_nettype none
module acb_temp_sensor (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Control
   input wire logic frame_start_in,
   input wire logic [7:0] interval_in,
   input wire logic powerdown_in,
   // Converter
   input wire logic adc_valid_in,
   input wire logic signed [9:0] adc_value_in,
   output logic convert_req_out,
   output logic sensor_power_out,
   // Result
   output logic [7:0] reading_out
);
   import acb_pkg::*;

   logic [7:0] frames_q;
   logic [7:0] interval_eff;

   // Codes below the valid range behave as the lowest valid one
   assign interval_eff = (interval_in < INTERVAL_MIN) ? INTERVAL_MIN : interval_in; // see [RQ18]

   // Counts frames; (interval + 1) frames between conversions
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         frames_q <= 8'h00; // see [RQ23]
      end else if (powerdown_in) begin
         frames_q <= interval_eff;
      end else if (frame_start_in) begin
         if (frames_q == 8'h00) begin
            frames_q <= interval_eff; // see [RQ23] [RQ18] [RQ20]
         end else begin
            frames_q <= frames_q - 8'h01;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         convert_req_out <= 1'b0;
      end else begin
         convert_req_out <= frame_start_in && frames_q == 8'h00 && !powerdown_in; // see [RQ22]
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sensor_power_out <= 1'b0;
      end else begin
         sensor_power_out <= !powerdown_in; // see [RQ22]
      end
   end

   // Saturating store, no wrap
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         reading_out <= RST_TEMPERATURE_READING;
      end else if (adc_valid_in && !powerdown_in) begin
         if (adc_value_in < 0) begin
            reading_out <= 8'h00; // see [RQ21]
         end else if (adc_value_in > 10'sd255) begin
            reading_out <= 8'hff; // see [RQ21]
         end else begin
            reading_out <= adc_value_in[7:0]; // see [RQ19]
         end
      end
   end
endmodule
`default_nettype wire

/* File: hw/acb_top.sv */
// Purpose: Analog control register bank of the display core
// Assumes: Register port is the internal side of the serial control port
// Notes:   All outputs registered; analog circuits sit outside
//
// How it works
// [RQ1] Reference-select bit 1 picks external reference, 0 internal default.
// [RQ2] Three-bit pixel bias; 000 sink off, 111 maximum, 3 recommended.
// [RQ3] Pump-hold bit suspends converter switching during gamma sampling.
// [RQ4] Gamma sense hold bit: 0 bypass hold, 1 activate hold.
// [RQ5] Gamma current step code n gives reference over 2^(7-n).
// [RQ6] Controller waits 10 ms after a step change, samples in blanking.
// [RQ7] Sense field 00 off, else on; overcurrent while on stops pump drive.
// [RQ8] Mode 00 fixed current, 01 clamped current, 10 manual voltage.
// [RQ9] Soft-start bypass bit skips soft-start; default applies it.
// [RQ10] Converter clock duty from 1:7 to 7:1; 3 is 1:1, 7 unused.
// [RQ11] Converter clock 125, 250, 500 or 900 kHz; 900 default.
// [RQ12] Soft-start lasts 2, 4, 8 or 16 ms; 4 ms default.
// [RQ13] Eight-bit pixel voltage ceiling code, default 0x0d, linear drop.
// [RQ14] Cathode level register is fixed target in modes 01 and 10.
// [RQ15] Peak current factor is coarse step plus fine thirty-seconds.
// [RQ16] Dimming scales luminance in 1 percent steps up to 127 percent.
// [RQ17] Dimming only acts in mode 00; otherwise no effect.
// [RQ18] Temperature refreshes every interval plus one frames; 2..255 valid.
// [RQ19] Each temperature sample lands in an eight-bit read-only register.
// [RQ20] Default interval refreshes temperature every 255 frames.
// [RQ21] Temperature reading saturates at 0 and 0xff.
// [RQ22] Sensor power-down stops sensing.
// [RQ23] Frame counter reloads after update, triggers on expiry, clears at reset.
`timescale 1ns/1ps
`default_nettype none
module acb_top #(
   parameter int unsigned SS_BASE_CYCLES = acb_pkg::SS_BASE_CYC
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Analog status
   input wire logic gamma_sample_in,
   input wire logic overcurrent_in,
   input wire logic frame_start_in,
   input wire logic temp_sensor_powerdown_in,
   input wire logic temp_adc_valid_in,
   input wire logic signed [9:0] temp_adc_value_in,
   // Bias and gamma sensor controls
   output logic external_ref_select_out,
   output logic [2:0] pixel_bias_level_out,
   output logic pixel_sink_enable_out,
   output logic gamma_sense_hold_enable_out,
   output logic [7:0] gamma_sensor_current_step_out,
   // Cathode converter controls
   output logic converter_pump_drive_out,
   output logic cathode_overcurrent_sense_enable_out,
   output logic fixed_current_regulation_out,
   output logic clamped_current_regulation_out,
   output logic manual_voltage_out,
   output logic [7:0] cathode_level_setting_out,
   output logic softstart_active_out,
   // Luminance and ceiling
   output logic [7:0] pixel_voltage_ceiling_out,
   output logic [7:0] peak_current_factor_out,
   output logic [6:0] dimming_scale_out,
   output logic [14:0] peak_luminance_out,
   // Temperature sensor
   output logic temp_convert_req_out,
   output logic temp_sensor_power_out,
   output logic [7:0] sensor_gain_out,
   output logic [7:0] sensor_offset_out
);
   import acb_pkg::*;

   logic [7:0] bias_control_q;
   logic [7:0] gamma_sensor_control_q;
   logic [7:0] cathode_mode_q;
   logic [7:0] cathode_converter_control_q;
   logic [7:0] pixel_voltage_ceiling_q;
   logic [7:0] cathode_level_q;
   logic [7:0] peak_current_reference_q;
   logic [7:0] dimming_level_q;
   logic [7:0] sensor_gain_q;
   logic [7:0] sensor_offset_q;
   logic [7:0] sensor_update_interval_q;
   logic [7:0] temperature_reading;
   logic [7:0] rdata_d;
   acb_conv_cfg_t conv_cfg;
   logic [1:0] conv_mode;
   logic sense_on;
   logic conv_clk;
   logic [2:0] coarse;
   logic [7:0] factor_d;
   logic [6:0] dim_d;
   acb_ss_state_t ss_state_q;
   logic [23:0] ss_cnt_q;
   logic [23:0] ss_len;

   // Register writes; the reading register ignores writes
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         bias_control_q <= RST_BIAS_CONTROL;
         gamma_sensor_control_q <= RST_GAMMA_SENSOR_CONTROL;
         cathode_mode_q <= RST_CATHODE_MODE;
         cathode_converter_control_q <= RST_CATHODE_CONVERTER_CONTROL;
         pixel_voltage_ceiling_q <= RST_PIXEL_VOLTAGE_CEILING;
         cathode_level_q <= RST_CATHODE_LEVEL;
         peak_current_reference_q <= RST_PEAK_CURRENT_REFERENCE;
         dimming_level_q <= RST_DIMMING_LEVEL;
         sensor_gain_q <= RST_SENSOR_GAIN;
         sensor_offset_q <= RST_SENSOR_OFFSET;
         sensor_update_interval_q <= RST_SENSOR_UPDATE_INTERVAL;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            OFS_BIAS_CONTROL: bias_control_q <= reg_wdata_in;
            OFS_GAMMA_SENSOR_CONTROL: gamma_sensor_control_q <= reg_wdata_in;
            OFS_CATHODE_MODE: cathode_mode_q <= reg_wdata_in;
            OFS_CATHODE_CONVERTER_CONTROL: cathode_converter_control_q <= reg_wdata_in;
            OFS_PIXEL_VOLTAGE_CEILING: pixel_voltage_ceiling_q <= reg_wdata_in; // see [RQ13]
            OFS_CATHODE_LEVEL: cathode_level_q <= reg_wdata_in;
            OFS_PEAK_CURRENT_REFERENCE: peak_current_reference_q <= reg_wdata_in;
            OFS_DIMMING_LEVEL: dimming_level_q <= reg_wdata_in;
            OFS_SENSOR_GAIN: sensor_gain_q <= reg_wdata_in;
            OFS_SENSOR_OFFSET: sensor_offset_q <= reg_wdata_in;
            OFS_SENSOR_UPDATE_INTERVAL: sensor_update_interval_q <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped offsets read zero
   always_comb begin
      case (reg_addr_in)
         OFS_BIAS_CONTROL: rdata_d = bias_control_q;
         OFS_GAMMA_SENSOR_CONTROL: rdata_d = gamma_sensor_control_q;
         OFS_CATHODE_MODE: rdata_d = cathode_mode_q;
         OFS_CATHODE_CONVERTER_CONTROL: rdata_d = cathode_converter_control_q;
         OFS_PIXEL_VOLTAGE_CEILING: rdata_d = pixel_voltage_ceiling_q;
         OFS_CATHODE_LEVEL: rdata_d = cathode_level_q;
         OFS_PEAK_CURRENT_REFERENCE: rdata_d = peak_current_reference_q;
         OFS_DIMMING_LEVEL: rdata_d = dimming_level_q;
         OFS_SENSOR_GAIN: rdata_d = sensor_gain_q;
         OFS_SENSOR_OFFSET: rdata_d = sensor_offset_q;
         OFS_SENSOR_UPDATE_INTERVAL: rdata_d = sensor_update_interval_q;
         OFS_TEMPERATURE_READING: rdata_d = temperature_reading; // see [RQ19]
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rdata_d;
      end
   end

   // Bias and reference
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         external_ref_select_out <= 1'b0;
         pixel_bias_level_out <= 3'h0;
         pixel_sink_enable_out <= 1'b0;
      end else begin
         external_ref_select_out <= bias_control_q[POS_EXT_REF]; // see [RQ1]
         pixel_bias_level_out <= bias_control_q[POS_BIAS_LSB +: 3]; // see [RQ2]
         pixel_sink_enable_out <= bias_control_q[POS_BIAS_LSB +: 3] != 3'h0; // see [RQ2]
      end
   end

   // Gamma sensor: one-hot divisor select, bit 7 is full reference
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         gamma_sense_hold_enable_out <= 1'b0;
         gamma_sensor_current_step_out <= 8'h80;
      end else begin
         gamma_sense_hold_enable_out <= gamma_sensor_control_q[POS_GSENSE_HOLD]; // see [RQ4]
         gamma_sensor_current_step_out <=
            8'h01 << gamma_sensor_control_q[POS_GSTEP_LSB +: 3]; // see [RQ5]
      end
   end

   // Converter mode decode
   assign conv_mode = cathode_mode_q[POS_MODE_LSB +: 2];
   assign sense_on = cathode_mode_q[POS_ISENSE_LSB +: 2] != 2'h0;

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         fixed_current_regulation_out <= 1'b1;
         clamped_current_regulation_out <= 1'b0;
         manual_voltage_out <= 1'b0;
         cathode_overcurrent_sense_enable_out <= 1'b0;
         cathode_level_setting_out <= RST_CATHODE_LEVEL;
      end else begin
         fixed_current_regulation_out <= conv_mode == MODE_FIXED_CURRENT; // see [RQ8]
         clamped_current_regulation_out <= conv_mode == MODE_CLAMPED_CURRENT; // see [RQ8]
         manual_voltage_out <= conv_mode == MODE_MANUAL_VOLTAGE; // see [RQ8]
         cathode_overcurrent_sense_enable_out <= sense_on; // see [RQ7]
         cathode_level_setting_out <= cathode_level_q; // see [RQ14]
      end
   end

   // Converter clock settings
   assign conv_cfg.freq = cathode_converter_control_q[POS_FREQ_LSB +: 2];
   assign conv_cfg.duty = cathode_converter_control_q[POS_DUTY_LSB +: 3];
   assign conv_cfg.ss_code = cathode_converter_control_q[POS_SS_LSB +: 2];
   assign conv_cfg.ss_bypass = cathode_converter_control_q[POS_SS_BYPASS];

   acb_conv_clock u_conv_clock (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .freq_in(conv_cfg.freq),
      .duty_in(conv_cfg.duty),
      .conv_clk_out(conv_clk)
   );

   // Soft-start timer after reset
   assign ss_len = 24'(SS_BASE_CYCLES) << conv_cfg.ss_code; // see [RQ12]

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ss_state_q <= SS_IDLE;
         ss_cnt_q <= 24'h000000;
      end else begin
         case (ss_state_q)
            SS_IDLE: begin
               ss_cnt_q <= 24'h000000;
               ss_state_q <= conv_cfg.ss_bypass ? SS_DONE : SS_RAMP; // see [RQ9]
            end
            SS_RAMP: begin
               if (conv_cfg.ss_bypass || ss_cnt_q >= ss_len - 24'h000001) begin
                  ss_state_q <= SS_DONE; // see [RQ9] [RQ12]
               end else begin
                  ss_cnt_q <= ss_cnt_q + 24'h000001;
               end
            end
            SS_DONE: ss_state_q <= SS_DONE;
            default: ss_state_q <= SS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         softstart_active_out <= 1'b1;
      end else begin
         softstart_active_out <= ss_state_q != SS_DONE;
      end
   end

   // Pump drive gated by sampling hold and overcurrent
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         converter_pump_drive_out <= 1'b0;
      end else if (gamma_sensor_control_q[POS_PUMP_HOLD] && gamma_sample_in) begin
         converter_pump_drive_out <= 1'b0; // see [RQ3]
      end else if (sense_on && overcurrent_in) begin
         converter_pump_drive_out <= 1'b0; // see [RQ7]
      end else begin
         converter_pump_drive_out <= conv_clk;
      end
   end

   // Peak current factor in 1/32 units; coarse codes above max saturate
   assign coarse = (peak_current_reference_q[POS_COARSE_LSB +: 3] > COARSE_MAX) ?
      COARSE_MAX : peak_current_reference_q[POS_COARSE_LSB +: 3];

   always_comb begin
      case (coarse)
         3'h0: factor_d = 8'h00;
         3'h1: factor_d = 8'h10;
         default: factor_d = 8'({coarse, 5'h00} - 8'h10);
      endcase
      factor_d = factor_d + {3'h0, peak_current_reference_q[POS_FINE_LSB +: 5]}; // see [RQ15]
   end

   // Dimming only applies in fixed-current mode
   assign dim_d = (conv_mode == MODE_FIXED_CURRENT) ? dimming_level_q[6:0] : DIM_UNITY; // see [RQ17]

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         peak_current_factor_out <= 8'h00;
         dimming_scale_out <= DIM_UNITY;
         peak_luminance_out <= 15'h0000;
         pixel_voltage_ceiling_out <= RST_PIXEL_VOLTAGE_CEILING;
      end else begin
         peak_current_factor_out <= factor_d; // see [RQ15]
         dimming_scale_out <= dim_d; // see [RQ16]
         peak_luminance_out <= 15'(factor_d * dim_d); // see [RQ16]
         pixel_voltage_ceiling_out <= pixel_voltage_ceiling_q; // see [RQ13]
      end
   end

   // Temperature sensor
   acb_temp_sensor u_temp_sensor (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .frame_start_in(frame_start_in),
      .interval_in(sensor_update_interval_q),
      .powerdown_in(temp_sensor_powerdown_in),
      .adc_valid_in(temp_adc_valid_in),
      .adc_value_in(temp_adc_value_in),
      .convert_req_out(temp_convert_req_out),
      .sensor_power_out(temp_sensor_power_out),
      .reading_out(temperature_reading)
   );

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         sensor_gain_out <= RST_SENSOR_GAIN;
         sensor_offset_out <= RST_SENSOR_OFFSET;
      end else begin
         sensor_gain_out <= sensor_gain_q;
         sensor_offset_out <= sensor_offset_q;
      end
   end
endmodule
`default_nettype wire

/* File: dv/acb_top_properties.sv */
// Purpose: Port-level assertions for the analog control register bank
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every acb_top instance below the module
`timescale 1ns/1ps
`default_nettype none
module acb_top_properties (
   // Clock, reset and status inputs
   input wire logic clock_in, rst_n_in, overcurrent_in, frame_start_in, temp_sensor_powerdown_in,
   // Watched outputs
   input wire logic [7:0] gamma_sensor_current_step_out, peak_current_factor_out,
   input wire logic converter_pump_drive_out, cathode_overcurrent_sense_enable_out,
   input wire logic fixed_current_regulation_out, clamped_current_regulation_out,
   input wire logic manual_voltage_out, temp_convert_req_out,
   input wire logic [6:0] dimming_scale_out,
   input wire logic [14:0] peak_luminance_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // Overcurrent seen while sensing is on, held long enough to pass the output stage
   sequence s_oc_held;
      (overcurrent_in && cathode_overcurrent_sense_enable_out)[*2];
   endsequence
   a_oc_stops_pump: assert property (s_oc_held |=> !converter_pump_drive_out)
      else $error("pump drive active under overcurrent");
   a_mode_onehot: assert property ($onehot0({fixed_current_regulation_out,
      clamped_current_regulation_out, manual_voltage_out})) else $error("mode not one-hot");
   a_dim_other_mode: assert property ((!fixed_current_regulation_out)[*2] |->
      dimming_scale_out == 7'h64) else $error("dimming acts outside mode 0");
   a_step_onehot: assert property ($onehot(gamma_sensor_current_step_out))
      else $error("current step not one-hot");
   a_lum_product: assert property (($stable(peak_current_factor_out) &&
      $stable(dimming_scale_out))[*2] |-> peak_luminance_out ==
      peak_current_factor_out * dimming_scale_out) else $error("luminance product wrong");
   a_req_single: assert property (temp_convert_req_out |=> !temp_convert_req_out)
      else $error("request longer than one cycle");
   a_req_after_frame: assert property (temp_convert_req_out |-> $past(frame_start_in))
      else $error("request without frame start");
   a_req_powerdown: assert property ($past(temp_sensor_powerdown_in) |->
      !temp_convert_req_out) else $error("request while powered down");
endmodule
bind acb_top acb_top_properties u_props (.*);
`default_nettype wire

/* File: dv/tb.sv */
// Purpose: Self-checking bench for the analog control register bank
// Assumes: Inputs driven at the falling edge; model array holds register values
// Notes:   Soft-start base shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acb_pkg::*;
   logic clk = 0, rst_n = 0, wr = 0, rd = 0, oc = 0, fs = 0, pd = 0, av = 0;
   logic [7:0] ad = 0, wd = 0, rdat, stp, fac, lvl, ceil, gain, offs, d;
   logic signed [9:0] avv = 0;
   logic [2:0] bias;
   logic [6:0] dim;
   logic [14:0] lum;
   logic xr, gh, sen, fx, cl, mv, ss, req, pmp, snk, tpw, gs = 0;
   logic [7:0] m [12:23] = '{8'h03, 8'h07, 8'h00, 8'h3d, 8'h0d, 8'h51, 8'h00, 8'h64, 8'h19,
      8'h5d, 8'hfe, 8'h00};
   int err_count = 0, total_checks = 0, nreq = 0, c;
   int tv [4] = '{-5, 300, 100, 255};
   acb_top #(.SS_BASE_CYCLES(20)) dut (.clock_in(clk), .rst_n_in(rst_n), .reg_addr_in(ad),
      .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
      .gamma_sample_in(gs), .overcurrent_in(oc), .frame_start_in(fs),
      .temp_sensor_powerdown_in(pd), .temp_adc_valid_in(av), .temp_adc_value_in(avv),
      .external_ref_select_out(xr), .pixel_bias_level_out(bias), .pixel_sink_enable_out(snk),
      .gamma_sense_hold_enable_out(gh), .gamma_sensor_current_step_out(stp),
      .converter_pump_drive_out(pmp), .cathode_overcurrent_sense_enable_out(sen),
      .fixed_current_regulation_out(fx), .clamped_current_regulation_out(cl),
      .manual_voltage_out(mv), .cathode_level_setting_out(lvl), .softstart_active_out(ss),
      .pixel_voltage_ceiling_out(ceil), .peak_current_factor_out(fac), .dimming_scale_out(dim),
      .peak_luminance_out(lum), .temp_convert_req_out(req), .temp_sensor_power_out(tpw),
      .sensor_gain_out(gain), .sensor_offset_out(offs));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (req === 1'b1) nreq++;
   task automatic chk(input logic [63:0] s, input logic [63:0] e);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("FAIL %0t got %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr_r(input int a, input logic [7:0] v);
      @(negedge clk) ad = 8'(a);
      wd = v;
      wr = 1;
      @(negedge clk) wr = 0;
      if (a > 11 && a < 23) m[a] = v;
   endtask
   task automatic rc(input int a);
      @(negedge clk) ad = 8'(a);
      rd = 1;
      @(negedge clk) rd = 0;
      chk(rdat, (a > 11 && a < 24) ? m[a] : 8'h00);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #500us err_count++;
      print_verdict();
   end
   initial begin
      void'($urandom(88087));
      repeat (4) @(negedge clk);
      rst_n = 1;
      chk(ss, 1);
      for (int a = 11; a < 25; a++) rc(a);
      $display("reset test done");
      for (int a = 12; a < 24; a++) wr_r(a, 8'($urandom));
      for (int a = 12; a < 24; a++) rc(a);
      chk({xr, bias, snk, lvl, ceil, gain, offs}, {m[12][7], m[12][2:0], m[12][2:0] != 0,
         m[17], m[16], m[20], m[21]});
      repeat (200) @(negedge clk);
      chk(ss, 0);
      $display("register test done");
      for (int i = 0; i < 16; i++) begin
         wr_r(14, 8'(i));
         wr_r(19, 8'($urandom_range(127)));
         wr_r(18, 8'($urandom));
         repeat (3) @(negedge clk);
         chk({sen, fx, cl, mv}, {i[3:2] != 0, i[1:0] == 0, i[1:0] == 1, i[1:0] == 2});
         d = i[1:0] == 0 ? m[19] : 8'h64;
         c = m[18][7:5] > 4 ? 4 : m[18][7:5];
         chk(fac, (c == 0 ? 0 : 32 * c - 16) + m[18][4:0]);
         chk({dim, lum}, {d[6:0], 15'(fac * d[6:0])});
      end
      $display("mode test done");
      for (int i = 0; i < 8; i++) begin
         wr_r(13, {1'b0, i[0], 3'h0, i[2:0]});
         repeat (2) @(negedge clk);
         chk({stp, gh}, {8'h01 << i, i[0]});
      end
      wr_r(14, 8'h04);
      wr_r(15, RST_CATHODE_CONVERTER_CONTROL);
      wr_r(13, 8'h80);
      for (int j = 0; j < 900; j++) begin
         gs = j < 300;
         oc = j >= 600;
         @(negedge clk) c = (j % 300) ? c + pmp : 0;
         if (j % 300 == 299) chk(c > 0, j == 599);
      end
      oc = 0;
      $display("sensor and overcurrent test done");
      wr_r(22, 8'h02);
      for (int k = 0; k < 15; k++) begin
         if (k == 9) pd = 1;
         @(negedge clk) fs = 1;
         @(negedge clk) fs = 0;
         repeat (3) @(negedge clk);
         if (k == 8) chk(nreq, 3);
      end
      chk(nreq, 3);
      chk(tpw, 0);
      pd = 0;
      foreach (tv[k]) begin
         @(negedge clk) av = 1;
         avv = 10'(tv[k]);
         @(negedge clk) av = 0;
         m[23] = 8'(tv[k] < 0 ? 0 : tv[k] > 255 ? 255 : tv[k]);
         rc(23);
      end
      $display("temperature test done");
      print_verdict();
   end
endmodule
`default_nettype wire
